// ### rtl/cho_consts.vh
// Constants for the charge option one register bank
// What this block does
// - High bit 7 enables current monitor buffer, forced off by low-power mode.
// - High bit 4 enables power sense and buffer, forced off by low-power mode.
// - High bit 3 picks input sense resistor, 0 is 10 mOhm, 1 is 20 mOhm.
// - High bit 2 picks charge sense resistor, 0 is 10 mOhm, 1 is 20 mOhm.
// - High bit 1 sets power monitor gain, 0 is 0.25, 1 is 1 uA/W.
// - High bit 0 picks limit pin low action: high impedance or pass-through.
// - Low bit 7 selects comparator reference, 0 is 2.3 V, 1 is 1.2 V.
// - Low bit 6 sets comparator output polarity against the reference.
// - Low bits 5:4 pick deglitch: 00 disables the comparator (output held high), then 1 us, 2 ms, 5 s.
// - Deglitch delays only the falling comparator output; rising is immediate.
// - Low bit 3 with tripped comparator opens both switches, drops charge good.
// - The latch-off state holds until the adapter is removed.
// - Low bit 2 enables pass-through mode; default off.
// - Writing low bit 1 starts shipping discharge; cleared by hardware after 140 ms.
// - Low bit 0 with battery below minimum starts 30 min 128 mA wake charge.
// - Battery above minimum during wake charge ends it and clears low bit 0.
// - High bit 6 is reserved, read-write, default zero.
`ifndef CHO_CONSTS_VH
`define CHO_CONSTS_VH
`define CHO_ADDR_LOW 8'h30
`define CHO_ADDR_HIGH 8'h31
`define CHO_RESET 16'h0211
`define CHO_B_AUTO_WAKE 0
`define CHO_B_SHIP 1
`define CHO_B_PTM_EN 2
`define CHO_B_LATCH_EN 3
`define CHO_B_DEG_LO 4
`define CHO_B_DEG_HI 5
`define CHO_B_POL 6
`define CHO_B_REF 7
`define CHO_B_PIN_SEL 8
`define CHO_B_GAIN 9
`define CHO_B_RSR 10
`define CHO_B_RAC 11
`define CHO_B_SYSTEM_POWER_MONITOR_EN 12
`define CHO_B_HOT_LP 13
`define CHO_B_RSVD 14
`define CHO_B_BATT_CURRENT_MONITOR_EN 15
`define CHO_CLK_HZ 20000000
`define CHO_DEG1_NS 1000
`define CHO_DEG1_CYC ((`CHO_DEG1_NS * 20 + 999) / 1000)
`define CHO_DEG2_MS 2
`define CHO_DEG2_CYC (`CHO_DEG2_MS * (`CHO_CLK_HZ / 1000))
`define CHO_DEG3_S 5
`define CHO_DEG3_CYC (`CHO_DEG3_S * `CHO_CLK_HZ)
`define CHO_SHIP_MS 140
`define CHO_SHIP_CYC (`CHO_SHIP_MS * (`CHO_CLK_HZ / 1000))
`define CHO_WAKE_MIN 30
// Thirty minutes of clocks does not fit in 32 bits, so the count is 36 bits wide
`define CHO_WAKE_CYC 36'd36000000000
`endif

// ### rtl/cho_sync.v
// Two-flop synchroniser for pin inputs
`default_nettype none
module cho_sync (
  input wire clock,
  input wire resetn,
  input wire d,
  output wire q
);
  reg s1_q;
  reg s2_q;
  always @(posedge clock) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // cho_sync
`default_nettype wire

// ### rtl/cho_charge_option_one.v
// Charge option one register bank with comparator, latch-off and timers
`include "cho_consts.vh"
`default_nettype none
module cho_charge_option_one #(
  parameter [31:0] DEG2_CYCLES = `CHO_DEG2_CYC,
  parameter [31:0] DEG3_CYCLES = `CHO_DEG3_CYC,
  parameter [31:0] SHIP_CYCLES = `CHO_SHIP_CYC,
  parameter [35:0] WAKE_CYCLES = `CHO_WAKE_CYC
) (
  input wire clock,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  output reg [7:0] reg_rdata,
  input wire low_power_mode_bit,
  input wire comparator_raw_above,
  input wire input_limit_pin,
  input wire adapter_present,
  input wire batt_below_min,
  output reg batt_current_buffer_en,
  output reg system_power_monitor_en,
  output reg hot_signal_lowpower_en,
  output reg input_sense_res_sel,
  output reg charge_sense_res_sel,
  output reg system_power_gain_sel,
  output reg comparator_reference_sel,
  output reg comparator_output,
  output reg high_impedance_mode,
  output reg pass_through_mode,
  output reg input_high_switch_off,
  output reg output_high_switch_off,
  output reg system_disconnect,
  output reg charge_good_force_low,
  output reg shipping_discharge_active,
  output reg wake_charge_active
);
  wire cmp_s;
  wire pin_s;
  wire adp_s;
  wire low_s;
  cho_sync u_sync_cmp (.clock(clock), .resetn(resetn), .d(comparator_raw_above), .q(cmp_s));
  cho_sync u_sync_pin (.clock(clock), .resetn(resetn), .d(input_limit_pin), .q(pin_s));
  cho_sync u_sync_adp (.clock(clock), .resetn(resetn), .d(adapter_present), .q(adp_s));
  cho_sync u_sync_low (.clock(clock), .resetn(resetn), .d(batt_below_min), .q(low_s));

  reg [15:0] opt_q;
  reg [15:0] opt_d;
  reg [31:0] deg_cnt_q;
  reg [31:0] ship_cnt_q;
  reg [35:0] wake_cnt_q;
  reg cmp_out_q;
  reg latch_q;
  reg wake_q;
  reg wake_done_q;
  wire [1:0] deg_sel;
  wire wr_lo;
  wire wr_hi;
  wire cmp_en;
  wire cmp_want_low;
  wire [31:0] deg_lim;
  wire ship_done;
  wire wake_end_ok;
  wire wake_timeout;
  wire cmp_tripped;

  assign wr_lo = reg_write && (reg_addr == `CHO_ADDR_LOW);
  assign wr_hi = reg_write && (reg_addr == `CHO_ADDR_HIGH);
  assign deg_sel = {opt_q[`CHO_B_DEG_HI], opt_q[`CHO_B_DEG_LO]};
  assign cmp_en = (deg_sel != 2'b00);
  // Polarity 0: low while above reference; 1: low while below
  assign cmp_want_low = opt_q[`CHO_B_POL] ? ~cmp_s : cmp_s;
  assign deg_lim = (deg_sel == 2'b01) ? `CHO_DEG1_CYC :
                   (deg_sel == 2'b10) ? DEG2_CYCLES : DEG3_CYCLES;
  assign ship_done = opt_q[`CHO_B_SHIP] && (ship_cnt_q >= SHIP_CYCLES - 32'h00000001);
  assign wake_end_ok = wake_q && !low_s;
  assign wake_timeout = wake_q && (wake_cnt_q >= WAKE_CYCLES - 36'h000000001);
  assign cmp_tripped = cmp_en && !cmp_out_q;

  // Register update; hardware clears applied last so they win
  always @* begin
    opt_d = opt_q;
    if (wr_lo) begin
      opt_d[7:0] = reg_wdata;
    end
    if (wr_hi) begin
      opt_d[15:8] = reg_wdata;
    end
    if (ship_done) begin
      opt_d[`CHO_B_SHIP] = 1'b0;
    end
    if (wake_end_ok) begin
      opt_d[`CHO_B_AUTO_WAKE] = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      opt_q <= `CHO_RESET;
    end else begin
      opt_q <= opt_d;
    end
  end

  always @* begin
    case (reg_addr)
      `CHO_ADDR_LOW: reg_rdata = opt_q[7:0];
      `CHO_ADDR_HIGH: reg_rdata = opt_q[15:8];
      default: reg_rdata = 8'h00;
    endcase
  end

  // Falling edge waits out the deglitch; rising passes at once
  always @(posedge clock) begin
    if (!resetn) begin
      cmp_out_q <= 1'b1;
      deg_cnt_q <= 32'h00000000;
    end else if (!cmp_en || !cmp_want_low) begin
      cmp_out_q <= 1'b1;
      deg_cnt_q <= 32'h00000000;
    end else if (cmp_out_q) begin
      if (deg_cnt_q >= deg_lim - 32'h00000001) begin
        cmp_out_q <= 1'b0;
        deg_cnt_q <= 32'h00000000;
      end else begin
        deg_cnt_q <= deg_cnt_q + 32'h00000001;
      end
    end
  end

  // Latch-off survives until the adapter goes away
  always @(posedge clock) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else if (!adp_s) begin
      latch_q <= 1'b0;
    end else if (opt_q[`CHO_B_LATCH_EN] && cmp_tripped) begin
      latch_q <= 1'b1;
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      ship_cnt_q <= 32'h00000000;
    end else if (!opt_q[`CHO_B_SHIP] || ship_done) begin
      ship_cnt_q <= 32'h00000000;
    end else begin
      ship_cnt_q <= ship_cnt_q + 32'h00000001;
    end
  end

  // Wake charge: one attempt per low-battery episode, bounded by the timer
  always @(posedge clock) begin
    if (!resetn) begin
      wake_q <= 1'b0;
      wake_done_q <= 1'b0;
      wake_cnt_q <= 36'h000000000;
    end else if (wake_q) begin
      if (wake_end_ok || wake_timeout || !opt_q[`CHO_B_AUTO_WAKE]) begin
        wake_q <= 1'b0;
        wake_done_q <= 1'b1;
        wake_cnt_q <= 36'h000000000;
      end else begin
        wake_cnt_q <= wake_cnt_q + 36'h000000001;
      end
    end else begin
      if (!low_s) begin
        wake_done_q <= 1'b0;
      end
      if (opt_q[`CHO_B_AUTO_WAKE] && low_s && !wake_done_q) begin
        wake_q <= 1'b1;
      end
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      batt_current_buffer_en <= 1'b0;
      system_power_monitor_en <= 1'b0;
      hot_signal_lowpower_en <= 1'b0;
      input_sense_res_sel <= 1'b0;
      charge_sense_res_sel <= 1'b0;
      system_power_gain_sel <= 1'b1;
      comparator_reference_sel <= 1'b0;
      comparator_output <= 1'b1;
      high_impedance_mode <= 1'b0;
      pass_through_mode <= 1'b0;
      input_high_switch_off <= 1'b0;
      output_high_switch_off <= 1'b0;
      system_disconnect <= 1'b0;
      charge_good_force_low <= 1'b0;
      shipping_discharge_active <= 1'b0;
      wake_charge_active <= 1'b0;
    end else begin
      batt_current_buffer_en <= opt_q[`CHO_B_BATT_CURRENT_MONITOR_EN] && !low_power_mode_bit;
      system_power_monitor_en <= opt_q[`CHO_B_SYSTEM_POWER_MONITOR_EN] && !low_power_mode_bit;
      hot_signal_lowpower_en <= opt_q[`CHO_B_HOT_LP];
      input_sense_res_sel <= opt_q[`CHO_B_RAC];
      charge_sense_res_sel <= opt_q[`CHO_B_RSR];
      system_power_gain_sel <= opt_q[`CHO_B_GAIN];
      comparator_reference_sel <= opt_q[`CHO_B_REF];
      comparator_output <= cmp_out_q;
      high_impedance_mode <= !pin_s && !opt_q[`CHO_B_PIN_SEL];
      pass_through_mode <= opt_q[`CHO_B_PTM_EN] || (!pin_s && opt_q[`CHO_B_PIN_SEL]);
      input_high_switch_off <= latch_q;
      output_high_switch_off <= latch_q;
      system_disconnect <= latch_q;
      charge_good_force_low <= latch_q;
      shipping_discharge_active <= opt_q[`CHO_B_SHIP];
      wake_charge_active <= wake_q;
    end
  end
endmodule // cho_charge_option_one
`default_nettype wire

// ### verif/cho_props.sv
// Checker for the charge option one register bank
`default_nettype none
module cho_props #(parameter [31:0] SHIP_CYCLES = 32) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [7:0] reg_rdata,
  input wire logic low_power_mode_bit,
  input wire logic comparator_raw_above,
  input wire logic adapter_present,
  input wire logic batt_current_buffer_en,
  input wire logic system_power_monitor_en,
  input wire logic comparator_output,
  input wire logic shipping_discharge_active,
  input wire logic input_high_switch_off
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SH = SHIP_CYCLES + 8;
  logic pol_q;
  logic [1:0] deg_q;
  // Shadow of the comparator mode, so pin relations know what was programmed
  always_ff @(posedge clock) begin
    if (!resetn) {pol_q, deg_q} <= 3'h1;
    else if (reg_write && reg_addr == 8'h30) {pol_q, deg_q} <= reg_wdata[6:4];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_ship_run;
    shipping_discharge_active [*8];
  endsequence
  sequence s_want_high;
    (!comparator_raw_above && !pol_q && deg_q != 2'h0) [*5];
  endsequence
  a_batt_current_monitor_lpm_gate: assert property (low_power_mode_bit |=> !batt_current_buffer_en)
    else $error("current buffer on in low power");
  a_system_power_monitor_lpm_gate: assert property (low_power_mode_bit |=> !system_power_monitor_en)
    else $error("power monitor on in low power");
  a_unmapped_read: assert property (reg_addr[7:1] != 7'h18 |-> reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_ship_self_clear: assert property ($rose(shipping_discharge_active) |-> s_ship_run ##[1:SH]
    !shipping_discharge_active) else $error("shipping discharge timing wrong");
  a_cmp_rise_fast: assert property (s_want_high |-> comparator_output)
    else $error("comparator rise delayed");
  a_cmp_fall_deglitch: assert property ($fell(comparator_output) && deg_q == 2'h1 && !pol_q
    |-> $past(comparator_raw_above, 8)) else $error("comparator fell without deglitch");
  a_latch_hold: assert property ((input_high_switch_off && adapter_present) [*4] |=>
    input_high_switch_off) else $error("latch-off dropped with adapter");
  a_latch_clear: assert property (!adapter_present [*6] |-> !input_high_switch_off)
    else $error("latch-off held without adapter");
endmodule // cho_props
bind cho_charge_option_one cho_props #(.SHIP_CYCLES(SHIP_CYCLES)) u_props (.clock, .resetn, .reg_addr,
  .reg_wdata, .reg_write, .reg_rdata, .low_power_mode_bit, .comparator_raw_above, .adapter_present,
  .batt_current_buffer_en, .system_power_monitor_en, .comparator_output, .shipping_discharge_active,
  .input_high_switch_off);
`default_nettype wire

// ### verif/cho_host_model.sv
// Host model writing and reading the option bytes
`default_nettype none
module cho_host_model (
  input wire logic clock,
  input wire logic adapter_present,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_write = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    // High-byte writes made while an adapter is present never arm the low-power hot bit
    reg_wdata = (a == 8'h31 && adapter_present) ? (d & 8'hDF) : d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    // Sample on the falling edge, where the read data has settled
    @(negedge clock);
    d = reg_rdata;
  endtask
endmodule // cho_host_model
`default_nettype wire

// ### verif/tb_top.sv
// Testbench for the charge option one register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, resetn = 1'b0, low_power_mode_bit = 1'b0, comparator_raw_above = 1'b0;
  logic input_limit_pin = 1'b1, adapter_present = 1'b0, batt_below_min = 1'b0, reg_write;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic batt_current_buffer_en, system_power_monitor_en, hot_signal_lowpower_en, input_sense_res_sel;
  logic charge_sense_res_sel, system_power_gain_sel, comparator_reference_sel, comparator_output;
  logic high_impedance_mode, pass_through_mode, input_high_switch_off, output_high_switch_off;
  logic system_disconnect, charge_good_force_low, shipping_discharge_active, wake_charge_active;
  logic [7:0] hv [4] = '{8'hFF, 8'h40, 8'hAA, 8'h55};
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  initial forever #25 clock = ~clock;
  cho_host_model host (.*);
  cho_charge_option_one #(.DEG2_CYCLES(8), .DEG3_CYCLES(16), .SHIP_CYCLES(32), .WAKE_CYCLES(64)) uut (.*);
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic wt(ref logic s, input logic l, input int m, output int k);
    for (k = 0; s !== l; k++) begin
      if (k == m) begin
        n_fail++;
        report_and_stop();
      end
      @(negedge clock);
    end
  endtask
  task automatic cmp_run(input logic [7:0] m, input logic lo, input int e);
    comparator_raw_above = !lo;
    host.wr(8'h30, m);
    cyc(4);
    comparator_raw_above = lo;
    if (e == 0) begin
      cyc(40);
      chk(comparator_output, 1'b1);
    end else begin
      wt(comparator_output, 1'b0, e + 8, n);
      chk(n >= e && n <= e + 6, 1'b1);
      comparator_raw_above = !lo;
      wt(comparator_output, 1'b1, 5, n);
    end
  endtask
  initial begin
    cyc(4);
    resetn = 1'b1;
    rdc(8'h31, 8'h02);
    rdc(8'h30, 8'h11);
    rdc(8'h32, 8'h00);
    foreach (hv[i]) for (int l = 0; l < 2; l++) begin
      low_power_mode_bit = l[0];
      host.wr(8'h31, hv[i]);
      cyc(2);
      rdc(8'h31, hv[i]);
      chk({2'h0, batt_current_buffer_en, system_power_monitor_en, hot_signal_lowpower_en, input_sense_res_sel,
        charge_sense_res_sel, system_power_gain_sel}, {2'h0, hv[i][7] & !l[0], hv[i][4] & !l[0], hv[i][5],
        hv[i][3:1]});
    end
    low_power_mode_bit = 1'b0;
    $display("test register bits done");
    input_limit_pin = 1'b0;
    cyc(4);
    chk({high_impedance_mode, pass_through_mode}, 8'h01);
    host.wr(8'h31, 8'h00);
    cyc(2);
    chk({high_impedance_mode, pass_through_mode}, 8'h02);
    input_limit_pin = 1'b1;
    host.wr(8'h30, 8'h94);
    cyc(4);
    chk({comparator_reference_sel, high_impedance_mode, pass_through_mode}, 8'h05);
    $display("test pin modes done");
    cmp_run(8'h00, 1'b1, 0);
    cmp_run(8'h10, 1'b1, 20);
    cmp_run(8'h20, 1'b1, 8);
    cmp_run(8'h30, 1'b1, 16);
    cmp_run(8'h50, 1'b0, 20);
    adapter_present = 1'b1;
    host.wr(8'h30, 8'h18);
    wt(input_high_switch_off, 1'b1, 40, n);
    chk({output_high_switch_off, system_disconnect, charge_good_force_low}, 8'h07);
    comparator_raw_above = 1'b0;
    cyc(30);
    chk(input_high_switch_off, 1'b1);
    adapter_present = 1'b0;
    wt(input_high_switch_off, 1'b0, 6, n);
    $display("test comparator done");
    host.wr(8'h30, 8'h02);
    rdc(8'h30, 8'h02);
    wt(shipping_discharge_active, 1'b1, 3, n);
    wt(shipping_discharge_active, 1'b0, 40, n);
    chk(n >= 28, 1'b1);
    rdc(8'h30, 8'h00);
    batt_below_min = 1'b1;
    host.wr(8'h30, 8'h01);
    wt(wake_charge_active, 1'b1, 6, n);
    batt_below_min = 1'b0;
    wt(wake_charge_active, 1'b0, 6, n);
    rdc(8'h30, 8'h00);
    batt_below_min = 1'b1;
    host.wr(8'h30, 8'h01);
    wt(wake_charge_active, 1'b1, 6, n);
    wt(wake_charge_active, 1'b0, 80, n);
    chk(n >= 60, 1'b1);
    rdc(8'h30, 8'h01);
    $display("test timers done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
